// File: verilog/fpw_defs.svh
`ifndef FPW_DEFS_SVH
`define FPW_DEFS_SVH
// Function
// - Below write-inhibit threshold all logic held reset, no instruction answered.
// - Write-class instructions discarded until write power-up delay expires after threshold.
// - Reads accepted once select delay after minimum supply has passed.
// - Leaving power-on reset gives standby mode with write enable latch cleared.
// - Supply falling below threshold stops all operations and ignores instructions.
// - Delivered state reads array bytes FFh and status register 00h.
// - Latch arm sets write enable latch; writes refused unless latch set.
`define FPW_CLK_MHZ        100
`define FPW_T_SELECT_US    200
`define FPW_T_WRITE_US     400
`define FPW_SELECT_CYC     (`FPW_T_SELECT_US * `FPW_CLK_MHZ)
`define FPW_WRITE_CYC      (`FPW_T_WRITE_US * `FPW_CLK_MHZ)
`define FPW_CNT_W          20
`define FPW_ERASED_BYTE    8'hff
`define FPW_STATUS_RESET   8'h00
`define FPW_OP_LATCH_ARM   8'h06
`define FPW_OP_LATCH_DROP  8'h04
`define FPW_OP_PAGE_WRITE  8'h02
`define FPW_OP_SECTOR_CLR  8'hd8
`define FPW_OP_ARRAY_CLR   8'hc7
`define FPW_OP_STATUS_WR   8'h01
`define FPW_OP_READ        8'h03
`define FPW_OP_FAST_READ   8'h0b
`define FPW_OP_STATUS_RD   8'h05
`endif

// File: verilog/fpw_pkg.sv
package fpw_pkg;
  typedef enum logic [1:0] {FPW_OFF, FPW_READ_ONLY, FPW_FULL} fpw_phase_type;
  typedef enum logic [1:0] {FPW_REFUSE, FPW_READ_CMD, FPW_WRITE_CMD, FPW_OTHER_CMD}
    fpw_class_type;
endpackage

// File: verilog/fpw_decode.sv
`timescale 1ns/1ps
`include "fpw_defs.svh"
module fpw_decode (
  input  wire logic [7:0]           opcode_i,
  output fpw_pkg::fpw_class_type    cls_o
);
  import fpw_pkg::*;
  always_comb begin
    case (opcode_i)
      `FPW_OP_READ, `FPW_OP_FAST_READ, `FPW_OP_STATUS_RD: cls_o = FPW_READ_CMD;
      `FPW_OP_LATCH_ARM, `FPW_OP_PAGE_WRITE, `FPW_OP_SECTOR_CLR,
      `FPW_OP_ARRAY_CLR, `FPW_OP_STATUS_WR: cls_o = FPW_WRITE_CMD;
      `FPW_OP_LATCH_DROP: cls_o = FPW_OTHER_CMD;
      default: cls_o = FPW_REFUSE;
    endcase
  end
endmodule

// File: verilog/fpw_gate.sv
`timescale 1ns/1ps
`include "fpw_defs.svh"
module fpw_gate (
  input  wire logic                  sys_clk_i,
  input  wire logic                  arst_n_i,
  input  wire logic                  above_inhibit_i,
  input  wire logic                  above_min_i,
  input  wire logic                  cmd_valid_i,
  input  wire logic [7:0]            cmd_op_i,
  input  wire logic                  cycle_done_i,
  output logic                       logic_reset_o,
  output logic                       read_ok_o,
  output logic                       write_ok_o,
  output logic                       cmd_accept_o,
  output logic                       cmd_reject_o,
  output logic                       cycle_start_o,
  output logic                       write_enable_latch_o,
  output logic                       cycle_busy_flag_o,
  output logic                       standby_o,
  output logic [7:0]                 status_o,
  output logic [7:0]                 erased_byte_o
);
  import fpw_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // One packed state word keeps every register in a single clocked process.
  typedef struct packed {
    logic [1:0]              inh_sync;
    logic [1:0]              min_sync;
    logic [`FPW_CNT_W-1:0]   sel_cnt;
    logic [`FPW_CNT_W-1:0]   wr_cnt;
    logic                    sel_done;
    logic                    wr_done;
    logic                    rst;
    logic                    rd_ok;
    logic                    wr_ok;
    logic                    acc;
    logic                    rej;
    logic                    start;
    logic                    write_enable_latch;
    logic                    busy;
    logic                    stby;
  } fpw_state_type;
  fpw_state_type st_reg, st_next;
  fpw_class_type cls;
  fpw_decode u_dec (.opcode_i(cmd_op_i), .cls_o(cls));
  // Timers park on their last count, so a supply that stays up never wraps them.
  localparam logic [`FPW_CNT_W-1:0] SEL_LAST = `FPW_CNT_W'(`FPW_SELECT_CYC - 1);
  localparam logic [`FPW_CNT_W-1:0] WR_LAST  = `FPW_CNT_W'(`FPW_WRITE_CYC - 1);
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic inh;
    logic mn;
    logic allowed;
    st_next = st_reg;
    inh = st_reg.inh_sync[1];
    mn  = st_reg.min_sync[1];
    allowed = 1'b0;
    // Supply comparators are asynchronous, so they are synchronised first.
    st_next.inh_sync = {st_reg.inh_sync[0], above_inhibit_i};
    st_next.min_sync = {st_reg.min_sync[0], above_min_i};
    st_next.acc = 1'b0;
    st_next.rej = 1'b0;
    st_next.start = 1'b0;
    if (!inh) begin
      // Whole block restarts; timers begin again on the next rise.
      st_next.sel_cnt = '0;
      st_next.wr_cnt = '0;
      st_next.sel_done = 1'b0;
      st_next.wr_done = 1'b0;
      st_next.rst = 1'b1;
      st_next.rd_ok = 1'b0;
      st_next.wr_ok = 1'b0;
      st_next.write_enable_latch = 1'b0;
      st_next.busy = 1'b0;
      st_next.stby = 1'b1;
    end else begin
      st_next.rst = 1'b0;
      if (!st_reg.wr_done) begin
        if (st_reg.wr_cnt == WR_LAST) st_next.wr_done = 1'b1;
        else st_next.wr_cnt = st_reg.wr_cnt + 1'b1;
      end
      // A dip below minimum supply restarts the select delay only.
      if (!mn) begin
        st_next.sel_cnt = '0;
        st_next.sel_done = 1'b0;
      end else if (!st_reg.sel_done) begin
        if (st_reg.sel_cnt == SEL_LAST) st_next.sel_done = 1'b1;
        else st_next.sel_cnt = st_reg.sel_cnt + 1'b1;
      end
      // Writes need both delays; reads need only the select delay.
      st_next.rd_ok = st_reg.sel_done;
      st_next.wr_ok = st_reg.sel_done && st_reg.wr_done;
      // The latch drops with the end of a self-timed cycle; in mid-cycle only a supply loss below threshold clears it.
      if (st_reg.busy && cycle_done_i) begin
        st_next.busy = 1'b0;
        st_next.write_enable_latch = 1'b0;
      end
      // A status read stays open while busy so the host can poll for the end of a cycle.
      if (cmd_valid_i) begin
        allowed = 1'b0;
        case (cls)
          FPW_READ_CMD: allowed = st_reg.rd_ok && (!st_reg.busy
                                  || cmd_op_i == `FPW_OP_STATUS_RD);
          FPW_OTHER_CMD: allowed = st_reg.rd_ok && !st_reg.busy;
          FPW_WRITE_CMD: begin
            if (cmd_op_i == `FPW_OP_LATCH_ARM)
              allowed = st_reg.wr_ok && !st_reg.busy;
            else
              allowed = st_reg.wr_ok && st_reg.write_enable_latch && !st_reg.busy;
          end
          default: allowed = 1'b0;
        endcase
        st_next.acc = allowed;
        st_next.rej = !allowed;
        if (allowed) begin
          if (cmd_op_i == `FPW_OP_LATCH_ARM) st_next.write_enable_latch = 1'b1;
          else if (cmd_op_i == `FPW_OP_LATCH_DROP) st_next.write_enable_latch = 1'b0;
          else if (cls == FPW_WRITE_CMD) begin
            st_next.busy = 1'b1;
            st_next.start = 1'b1;
          end
          st_next.stby = 1'b0;
        end
      end else if (!st_next.busy) begin
        st_next.stby = 1'b1;
      end
    end
  end
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // Reset leaves the block held and idle until the supply is seen above threshold.
      st_reg <= '0;
      st_reg.rst <= 1'b1;
      st_reg.stby <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic_reset_o        = st_reg.rst;
    read_ok_o            = st_reg.rd_ok;
    write_ok_o           = st_reg.wr_ok;
    cmd_accept_o         = st_reg.acc;
    cmd_reject_o         = st_reg.rej;
    cycle_start_o        = st_reg.start;
    write_enable_latch_o = st_reg.write_enable_latch;
    cycle_busy_flag_o    = st_reg.busy;
    standby_o            = st_reg.stby;
    // Status bits are only the two live flags; others start and stay zero.
    status_o             = `FPW_STATUS_RESET | {6'h00, st_reg.write_enable_latch, st_reg.busy};
    erased_byte_o        = `FPW_ERASED_BYTE;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Every answer is registered, so checks on a request look one cycle later.
  // A request in the very cycle the synchronised supply drops gets no answer,
  // which is why the request checks also ask for the supply to be up.
  a_reset_holds: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !st_reg.inh_sync[1] |=> logic_reset_o && !write_enable_latch_o)
    else $error("logic not held reset below threshold");
  a_no_answer_off: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    logic_reset_o |-> !cmd_accept_o && !cycle_start_o)
    else $error("command accepted during reset");
  a_write_needs_delay: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cycle_start_o |-> $past(write_ok_o) && $past(write_enable_latch_o))
    else $error("write started too early or without latch");
  a_latch_arm_sets: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_valid_i && cmd_op_i == `FPW_OP_LATCH_ARM && write_ok_o && !cycle_busy_flag_o
    && st_reg.inh_sync[1] |=> write_enable_latch_o && cmd_accept_o)
    else $error("latch arm not honoured");
  a_read_after_sel: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_valid_i && cmd_op_i == `FPW_OP_READ && read_ok_o && !cycle_busy_flag_o
    && st_reg.inh_sync[1] |=> cmd_accept_o)
    else $error("read refused after select delay");
  a_write_blocked: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_valid_i && cmd_op_i == `FPW_OP_LATCH_ARM && !write_ok_o && st_reg.inh_sync[1]
    |=> cmd_reject_o)
    else $error("early latch arm not discarded");
  a_standby_reset: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $fell(logic_reset_o) |-> standby_o && !write_enable_latch_o)
    else $error("did not leave reset in standby");
  a_status_clean: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    status_o[7:2] == 6'h00 && erased_byte_o == `FPW_ERASED_BYTE)
    else $error("delivery values wrong");
  a_sync_delay: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    !above_inhibit_i [*3] |=> logic_reset_o)
    else $error("threshold loss not seen in three cycles");
  a_read_refused_early: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_valid_i && cls == FPW_READ_CMD && !read_ok_o && st_reg.inh_sync[1]
    |=> cmd_reject_o && !cmd_accept_o)
    else $error("read answered before select delay");
  a_busy_refuses_read: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_valid_i && cmd_op_i == `FPW_OP_READ && cycle_busy_flag_o && st_reg.inh_sync[1]
    |=> cmd_reject_o)
    else $error("read taken during a write cycle");
  a_write_needs_latch: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_valid_i && cmd_op_i == `FPW_OP_PAGE_WRITE && !write_enable_latch_o
    && st_reg.inh_sync[1] |=> cmd_reject_o && !cycle_start_o)
    else $error("write accepted without latch");
  a_done_clears_latch: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cycle_busy_flag_o && cycle_done_i && st_reg.inh_sync[1]
    |=> !cycle_busy_flag_o && !write_enable_latch_o)
    else $error("cycle end did not clear busy and latch");
  a_drop_clears_all: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $fell(st_reg.inh_sync[1]) |=> logic_reset_o && !cycle_busy_flag_o && !write_ok_o
    && !read_ok_o)
    else $error("supply loss did not stop operations");
  a_timer_full_length: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    write_ok_o |-> st_reg.wr_cnt == WR_LAST)
    else $error("write gate opened before full delay");
  // Covers mark the power-up, write, refusal and power-loss paths the bench must reach.
  c_read_only: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    read_ok_o && !write_ok_o);
  c_write_start: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cycle_start_o);
  c_power_drop: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(logic_reset_o));
  c_refused: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    cmd_reject_o);
  c_latch_set: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
    $rose(write_enable_latch_o));
endmodule

// File: dv/fpw_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host side of the command path. It sends one command at a time and never
// overlaps two, so every answer belongs to the last request.
module fpw_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       accept_i,
  input  wire logic       reject_i,
  output logic            cmd_valid_o,
  output logic [7:0]      cmd_op_o,
  output logic            cycle_done_o
);
  initial begin
    cmd_valid_o  = 1'b0;
    cmd_op_o     = 8'h00;
    cycle_done_o = 1'b0;
  end
  // The answer may land in either of the two cycles after the request, so both are collected.
  task automatic issue(input logic [7:0] op, output logic [1:0] ans);
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o    = op;
    @(negedge sys_clk_i);
    cmd_valid_o = 1'b0;
    cmd_op_o    = ~op;
    ans         = {accept_i, reject_i};
    @(negedge sys_clk_i);
    ans = ans | {accept_i, reject_i};
  endtask
  // Self-timed cycle ends after n cycles; a slow end is just a larger n.
  task automatic finish_cycle(input int n);
    repeat (n) @(negedge sys_clk_i);
    cycle_done_o = 1'b1;
    @(negedge sys_clk_i);
    cycle_done_o = 1'b0;
  endtask
endmodule

// File: dv/test_flash_powerup_write_inhibit.sv
`timescale 1ns/1ps
`include "fpw_defs.svh"
`define CHK(a, b) checks_done++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); \
  end
////////////////////////////////////////////////////////////////////////////////
module test_flash_powerup_write_inhibit;
  typedef struct {logic [7:0] op; logic [1:0] ans; logic write_enable_latch;} fpw_row_type;
  logic       clk, arst_n, inh, minok, vld, done, lrst, rok, wok, acc, rej, start, write_enable_latch, busy, stby;
  logic [7:0] op, status, erased;
  logic [1:0] ans;
  int         errors, checks_done, n, starts;
  logic [7:0] wops [4] = '{`FPW_OP_PAGE_WRITE, `FPW_OP_SECTOR_CLR, `FPW_OP_ARRAY_CLR,
                           `FPW_OP_STATUS_WR};
  fpw_row_type rows [6] = '{'{`FPW_OP_READ, 2'b10, 1'b0}, '{`FPW_OP_PAGE_WRITE, 2'b01, 1'b0},
    '{`FPW_OP_LATCH_ARM, 2'b10, 1'b1}, '{`FPW_OP_LATCH_DROP, 2'b10, 1'b0},
    '{`FPW_OP_STATUS_RD, 2'b10, 1'b0}, '{8'hee, 2'b01, 1'b0}};
  always #5 clk = ~clk;
  // Cycle start is a one-cycle pulse, so it is counted rather than sampled by a check.
  always @(negedge clk) begin
    if (start === 1'b1) starts++;
  end
  fpw_gate dut (.sys_clk_i(clk), .arst_n_i(arst_n), .above_inhibit_i(inh), .above_min_i(minok),
    .cmd_valid_i(vld), .cmd_op_i(op), .cycle_done_i(done), .logic_reset_o(lrst),
    .read_ok_o(rok), .write_ok_o(wok), .cmd_accept_o(acc), .cmd_reject_o(rej),
    .cycle_start_o(start), .write_enable_latch_o(write_enable_latch), .cycle_busy_flag_o(busy),
    .standby_o(stby), .status_o(status), .erased_byte_o(erased));
  fpw_host_model host (.sys_clk_i(clk), .accept_i(acc), .reject_i(rej), .cmd_valid_o(vld),
    .cmd_op_o(op), .cycle_done_o(done));
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // The run needs about 40100 cycles; the margin covers a stuck timer.
  initial begin
    #700000;
    errors++;
    summarize();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    inh = 1'b0;
    minok = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(lrst, 1'b1)
    `CHK(stby, 1'b1)
    `CHK(status, `FPW_STATUS_RESET)
    `CHK(erased, `FPW_ERASED_BYTE)
    host.issue(`FPW_OP_READ, ans);
    `CHK(ans, 2'b00)
    inh = 1'b1;
    minok = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(lrst, 1'b0)
    `CHK(write_enable_latch, 1'b0)
    repeat (10000) @(negedge clk);
    host.issue(`FPW_OP_READ, ans);
    `CHK(ans, 2'b01)
    repeat (15000) @(negedge clk);
    `CHK(rok, 1'b1)
    host.issue(`FPW_OP_READ, ans);
    `CHK(ans, 2'b10)
    host.issue(`FPW_OP_LATCH_ARM, ans);
    `CHK(ans, 2'b01)
    n = 0;
    while (wok !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    `CHK(n inside {[14000:16000]}, 1'b1)
    foreach (rows[i]) begin
      host.issue(rows[i].op, ans);
      `CHK(ans, rows[i].ans)
      `CHK(write_enable_latch, rows[i].write_enable_latch)
    end
    `CHK(starts, 0)
    foreach (wops[i]) begin
      host.issue(`FPW_OP_LATCH_ARM, ans);
      host.issue(wops[i], ans);
      `CHK(ans, 2'b10)
      `CHK(busy, 1'b1)
      `CHK(status, 8'h03)
      `CHK(starts, i + 1)
      host.issue(`FPW_OP_READ, ans);
      `CHK(ans, 2'b01)
      host.finish_cycle(3);
      repeat (2) @(negedge clk);
      `CHK({write_enable_latch, busy}, 2'b00)
    end
    // Supply is pulled in mid-cycle on purpose to see the cycle abandoned.
    host.issue(`FPW_OP_LATCH_ARM, ans);
    host.issue(`FPW_OP_PAGE_WRITE, ans);
    `CHK(starts, 5)
    inh = 1'b0;
    repeat (5) @(negedge clk);
    `CHK({lrst, write_enable_latch, busy, wok}, 4'b1000)
    `CHK({stby, rok}, 2'b10)
    host.issue(`FPW_OP_READ, ans);
    `CHK(ans, 2'b00)
    summarize();
  end
endmodule
